// [src/rivm_top.sv]
// reset and interrupt vector map with timed table relocation
`timescale 1ns/1ps
module rivm_top
  import rivm_pkg::*;
#(
  parameter logic LARGE_VARIANT = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic boot_reset_select_fuse_i,
  input wire logic [PC_W-1:0] boot_start_addr_i,
  input wire logic [NUM_SRC-1:0] src_req_i,
  input wire logic global_int_enable_i,
  input wire logic irq_ack_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic [PC_W-1:0] reset_vector_o,
  output logic irq_valid_o,
  output logic [PC_W-1:0] irq_vector_o,
  output logic [IDX_W-1:0] irq_index_o,
  output logic int_blocked_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // fuse pins arrive from outside the clock domain

  logic [PC_W:0] pins_sync;
  logic fuse_lvl;
  logic [PC_W-1:0] boot_start;

  rivm_sync #(
    .WIDTH(PC_W + 1)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .pin_i({boot_reset_select_fuse_i, boot_start_addr_i}),
    .level_o(pins_sync)
  );

  assign fuse_lvl = pins_sync[PC_W];
  assign boot_start = pins_sync[PC_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  logic wr_ctrl;
  logic wr_en;
  logic wr_mask;
  logic rd_status;
  logic wr_change_set;
  logic wr_select;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CONTROL);
  assign wr_en = reg_wr_i && (reg_addr_i == OFS_SRC_ENABLE);
  assign wr_mask = reg_wr_i && (reg_addr_i == OFS_IRQ_MASK);
  assign rd_status = reg_rd_i && (reg_addr_i == OFS_IRQ_STATUS);
  assign wr_change_set = wr_ctrl && reg_wdata_i[CTRL_CHANGE_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // timed change sequence for the table select

  logic [2:0] window_ff;
  logic [2:0] after_ff;
  logic select_ff;
  logic armed;
  logic expired;
  logic blocked;

  assign armed = (window_ff != 3'h0);
  // a select write only counts while the window is open and change enable is written 0
  assign wr_select = wr_ctrl && armed && !reg_wdata_i[CTRL_CHANGE_EN_BIT];
  assign expired = (window_ff == 3'h1) && !wr_select && !wr_change_set;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      window_ff <= 3'h0;
    end else if (wr_change_set) begin
      window_ff <= CHANGE_WINDOW_CYCLES;
    end else if (wr_select) begin
      window_ff <= 3'h0;
    end else if (armed) begin
      window_ff <= window_ff - 3'h1;
    end
  end

  // the blocking outlives the select write by one instruction slot
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      after_ff <= 3'h0;
    end else if (wr_select) begin
      after_ff <= AFTER_WRITE_CYCLES;
    end else if (after_ff != 3'h0) begin
      after_ff <= after_ff - 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      select_ff <= 1'b0;
    end else if (wr_select) begin
      select_ff <= reg_wdata_i[CTRL_SELECT_BIT];
    end
  end

  // blocking starts in the very cycle change enable is written; global enable untouched
  assign blocked = wr_change_set || armed || wr_select || (after_ff != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // vector addresses

  logic [PC_W-1:0] table_base;
  logic [PC_W-1:0] nxt_reset_vec;
  logic [PC_W-1:0] reset_vec_ff;

  assign table_base = select_ff ? boot_start : APP_TABLE_BASE;
  // the same vector serves pin, power-on, brown-out, watchdog and debug resets
  assign nxt_reset_vec = (fuse_lvl == FUSE_PROGRAMMED) ? boot_start
                                                       : APP_RESET_ADDR;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_vec_ff <= APP_RESET_ADDR;
    end else begin
      reset_vec_ff <= nxt_reset_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request selection

  logic [NUM_SRC-1:0] src_en_ff;
  logic [NUM_SRC-1:0] variant_mask;
  logic [NUM_SRC-1:0] live_req;
  logic found;
  logic [IDX_W-1:0] pick_idx;
  logic [PC_W-1:0] pick_vec;

  assign variant_mask = LARGE_VARIANT ? LARGE_SRC_MASK : SMALL_SRC_MASK;
  // disabled sources never reach the pick, so their vectors are never fetched
  assign live_req = src_req_i & src_en_ff & variant_mask;

  rivm_prio u_prio (
    .req_i(live_req),
    .found_o(found),
    .idx_o(pick_idx)
  );

  // index 0 is external request 0 at +0x0002, each next source one step further
  assign pick_vec = table_base + VEC_STEP + PC_W'({pick_idx, 1'b0});

  logic valid_ff;
  logic [PC_W-1:0] vec_ff;
  logic [IDX_W-1:0] idx_ff;
  logic blocked_ff;
  logic taken;

  assign taken = valid_ff && irq_ack_i;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_ff <= 1'b0;
      vec_ff <= APP_TABLE_BASE;
      idx_ff <= '0;
    end else begin
      valid_ff <= found && global_int_enable_i && !blocked && !taken;
      vec_ff <= pick_vec;
      idx_ff <= pick_idx;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blocked_ff <= 1'b0;
    end else begin
      blocked_ff <= blocked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers and event interrupt

  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] mask_ff;
  logic [EV_W-1:0] ev_set;
  logic irq_ff;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_en_ff <= SRC_ENABLE_RST;
    end else if (wr_en) begin
      src_en_ff <= reg_wdata_i[NUM_SRC-1:0] & variant_mask;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_ff <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= reg_wdata_i[EV_W-1:0];
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[EV_TABLE_MOVED] = wr_select && (reg_wdata_i[CTRL_SELECT_BIT] != select_ff);
    ev_set[EV_WINDOW_EXPIRED] = expired;
    ev_set[EV_VECTOR_TAKEN] = taken;
  end

  // an event in the same cycle as the clearing read survives it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~{EV_W{rd_status}}) | ev_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((status_ff & ~{EV_W{rd_status}}) | ev_set) & mask_ff);
    end
  end

  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] rdata_ff;

  always_comb begin
    nxt_rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_CONTROL: begin
          nxt_rdata[CTRL_CHANGE_EN_BIT] = armed;
          nxt_rdata[CTRL_SELECT_BIT] = select_ff;
          nxt_rdata[CTRL_BLOCKED_BIT] = blocked;
        end
        OFS_SRC_ENABLE: nxt_rdata[NUM_SRC-1:0] = src_en_ff;
        OFS_IRQ_STATUS: nxt_rdata[EV_W-1:0] = status_ff;
        OFS_IRQ_MASK: nxt_rdata[EV_W-1:0] = mask_ff;
        OFS_PENDING: nxt_rdata[NUM_SRC-1:0] = live_req;
        OFS_VECTORS: nxt_rdata = {table_base, reset_vec_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reset_vector_o = reset_vec_ff;
  assign irq_valid_o = valid_ff;
  assign irq_vector_o = vec_ff;
  assign irq_index_o = idx_ff;
  assign int_blocked_o = blocked_ff;
  assign irq_o = irq_ff;

endmodule

// [include/rivm_pkg.sv]
// constants, register map and field layout of the reset and interrupt vector map
package rivm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PC_W = 16;
  localparam int NUM_SRC = 24;
  localparam int IDX_W = 5;

  // sources in vector order; vector address is 2 * (index + 1) from the table base
  localparam logic [4:0] SRC_EXT0 = 5'h00;
  localparam logic [4:0] SRC_PCHG0 = 5'h01;
  localparam logic [4:0] SRC_PCHG1 = 5'h02;
  localparam logic [4:0] SRC_PCHG2 = 5'h16;
  localparam logic [4:0] SRC_PCHG3 = 5'h17;
  localparam logic [PC_W-1:0] VEC_STEP = 16'h0002;
  localparam logic [PC_W-1:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [PC_W-1:0] APP_TABLE_BASE = 16'h0000;

  // the large variant keeps all sources, the small one drops the last two
  localparam logic [NUM_SRC-1:0] LARGE_SRC_MASK = 24'hFFFFFF;
  localparam logic [NUM_SRC-1:0] SMALL_SRC_MASK = 24'h3FFFFF;

  localparam logic FUSE_PROGRAMMED = 1'b0;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SRC_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VECTORS = 8'h14;

  // control register fields
  localparam int CTRL_CHANGE_EN_BIT = 0;
  localparam int CTRL_SELECT_BIT = 1;
  localparam int CTRL_BLOCKED_BIT = 2;

  // interrupt status fields
  localparam int EV_W = 3;
  localparam int EV_TABLE_MOVED = 0;
  localparam int EV_WINDOW_EXPIRED = 1;
  localparam int EV_VECTOR_TAKEN = 2;

  // reset values
  localparam logic [NUM_SRC-1:0] SRC_ENABLE_RST = 24'h000000;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;

  // timed change sequence counts
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] AFTER_WRITE_CYCLES = 3'h1;

endpackage

// [src/rivm_sync.sv]
// three flop input synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
module rivm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      // meta_ff is read only by s2_ff
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_ff <= 1'b1;
          s2_ff <= 1'b1;
          s3_ff <= 1'b1;
          lvl_ff <= 1'b1;
        end else begin
          meta_ff <= pin_i[g];
          s2_ff <= meta_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
          end
        end
      end
      assign level_o[g] = lvl_ff;
    end
  endgenerate

endmodule

// [src/rivm_prio.sv]
// fixed priority pick: lowest index, which is the lowest vector address
`timescale 1ns/1ps
module rivm_prio
  import rivm_pkg::*;
(
  input wire logic [NUM_SRC-1:0] req_i,
  output logic found_o,
  output logic [IDX_W-1:0] idx_o
);

  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    // scan downward so the lowest set bit is the last one kept
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o = IDX_W'(i);
      end
    end
  end

endmodule

// [sim/rivm_checker_assertions.sv]
// port-level assertions for the vector map
`timescale 1ns/1ps
module rivm_checker
  import rivm_pkg::*;
#(
  parameter logic LARGE_VARIANT = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic boot_reset_select_fuse_i,
  input wire logic [PC_W-1:0] boot_start_addr_i,
  input wire logic [NUM_SRC-1:0] src_req_i,
  input wire logic global_int_enable_i,
  input wire logic irq_ack_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [PC_W-1:0] reset_vector_o,
  input wire logic irq_valid_o,
  input wire logic [PC_W-1:0] irq_vector_o,
  input wire logic [IDX_W-1:0] irq_index_o,
  input wire logic int_blocked_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
  property p_vec_calc;
    irq_valid_o |-> irq_vector_o == 16'h0002 + {irq_index_o, 1'b0} ||
      irq_vector_o == boot_start_addr_i + 16'h0002 + {irq_index_o, 1'b0};
  endproperty
  a_vec_calc: assert property (p_vec_calc) else $error("vector address wrong");
  // a vector is offered only for a request seen the cycle before
  property p_src_seen;
    irq_valid_o |-> (($past(src_req_i) >> irq_index_o) & 24'h000001) != 24'h000000;
  endproperty
  a_src_seen: assert property (p_src_seen) else $error("vector without request");
  property p_variant;
    irq_valid_o |-> irq_index_o < (LARGE_VARIANT ? 5'h18 : 5'h16);
  endproperty
  a_variant: assert property (p_variant) else $error("absent source offered");
  property p_ack_drop;
    irq_ack_i && irq_valid_o |=> !irq_valid_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("offer held after acknowledge");
  property p_gie_off;
    !global_int_enable_i |=> !irq_valid_o;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("offer with core interrupts off");
  property p_block_offer;
    int_blocked_o |-> !irq_valid_o;
  endproperty
  a_block_offer: assert property (p_block_offer) else $error("offer while blocked");
  property p_block_len;
    $rose(int_blocked_o) |-> int_blocked_o [*3] ##[1:4] !int_blocked_o;
  endproperty
  a_block_len: assert property (p_block_len) else $error("blocking length wrong");
  // the fuse is synchronised, so allow its pipeline to settle first
  property p_reset_app;
    boot_reset_select_fuse_i [*8] |-> reset_vector_o == 16'h0000;
  endproperty
  a_reset_app: assert property (p_reset_app) else $error("reset vector not zero");
  property p_reset_boot;
    (!boot_reset_select_fuse_i) [*8] |-> reset_vector_o == boot_start_addr_i;
  endproperty
  a_reset_boot: assert property (p_reset_boot) else $error("reset vector not boot");
endmodule
bind rivm_top rivm_checker #(.LARGE_VARIANT(LARGE_VARIANT)) i_rivm_checker (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .boot_reset_select_fuse_i(boot_reset_select_fuse_i), .boot_start_addr_i(boot_start_addr_i),
  .src_req_i(src_req_i), .global_int_enable_i(global_int_enable_i), .irq_ack_i(irq_ack_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reset_vector_o(reset_vector_o),
  .irq_valid_o(irq_valid_o), .irq_vector_o(irq_vector_o), .irq_index_o(irq_index_o),
  .int_blocked_o(int_blocked_o), .irq_o(irq_o));

// [sim/rivm_core_model.sv]
// processor core fetch and acknowledge model
`timescale 1ns/1ps
module rivm_core_model
  import rivm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic irq_valid_i,
  input wire logic [PC_W-1:0] irq_vector_i,
  input wire logic [3:0] delay_i,
  output logic irq_ack_o,
  output logic [PC_W-1:0] taken_vec_o,
  output logic [7:0] n_taken_o
);
  logic [3:0] wait_ff;
  // only an offered vector is fetched; a dropped offer restarts the wait
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_ack_o <= 1'b0;
      taken_vec_o <= '0;
      n_taken_o <= 8'h00;
      wait_ff <= 4'h0;
    end else if (irq_ack_o) begin
      irq_ack_o <= 1'b0;
      wait_ff <= 4'h0;
    end else if (irq_valid_i && wait_ff == delay_i) begin
      irq_ack_o <= 1'b1;
      taken_vec_o <= irq_vector_i;
      n_taken_o <= n_taken_o + 8'h01;
    end else if (irq_valid_i) begin
      wait_ff <= wait_ff + 4'h1;
    end else begin
      wait_ff <= 4'h0;
    end
  end
endmodule

// [sim/tb_top.sv]
// self-checking bench for the reset and interrupt vector map
`timescale 1ns/1ps
module tb_top;
  import rivm_pkg::*;
  localparam logic [PC_W-1:0] BOOT = 16'h3800;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic fuse = 1'b1;
  logic [NUM_SRC-1:0] req = '0;
  logic gie = 1'b0;
  logic ack;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [DATA_W-1:0] rdata, d;
  logic [PC_W-1:0] rvec, ivec, tvec;
  logic ivalid, blocked, irq;
  logic [IDX_W-1:0] iidx;
  logic [7:0] ntk;
  int err_count = 0;
  int n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  rivm_top i_rivm_top (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .boot_reset_select_fuse_i(fuse), .boot_start_addr_i(BOOT), .src_req_i(req),
    .global_int_enable_i(gie), .irq_ack_i(ack), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reset_vector_o(rvec),
    .irq_valid_o(ivalid), .irq_vector_o(ivec), .irq_index_o(iidx),
    .int_blocked_o(blocked), .irq_o(irq));
  rivm_core_model i_rivm_core_model (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .irq_valid_i(ivalid), .irq_vector_i(ivec), .delay_i(dly), .irq_ack_o(ack),
    .taken_vec_o(tvec), .n_taken_o(ntk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // a stuck offer ends the run rather than hanging it
  task automatic wait_taken(input logic [7:0] n0);
    for (int i = 0; i < 60 && ntk === n0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (ntk === n0) begin
      chk({24'h0, ntk}, {24'h0, n0 + 8'h01});
      wrap_up();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic f);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    fuse <= f;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 chk({16'h0, rvec}, f ? 32'h0 : {16'h0, BOOT});
    rd_reg(OFS_SRC_ENABLE);
    chk(d, 32'h0);
    rd_reg(OFS_IRQ_MASK);
    chk(d, 32'h0);
  endtask
  task automatic sc_vectors();
    logic [7:0] n0;
    wr_reg(OFS_SRC_ENABLE, 32'h00FFFFFF);
    gie <= 1'b1;
    for (int i = 0; i < NUM_SRC; i++) begin
      n0 = ntk;
      @(posedge sys_clk);
      req <= 24'h000001 << i;
      wait_taken(n0);
      chk({16'h0, tvec}, 32'h2 + 32'(2 * i));
      @(posedge sys_clk);
      req <= '0;
    end
  endtask
  task automatic sc_prio();
    logic [7:0] n0;
    wr_reg(OFS_SRC_ENABLE, 32'h00000028);
    gie <= 1'b0;
    dly <= 4'h5;
    req <= 24'h00002A;
    n0 = ntk;
    repeat (15) @(posedge sys_clk);
    #1 chk({24'h0, ntk}, {24'h0, n0});
    rd_reg(OFS_PENDING);
    chk(d, 32'h00000028);
    @(posedge sys_clk);
    gie <= 1'b1;
    wait_taken(n0);
    chk({16'h0, tvec}, 32'h0008);
    @(posedge sys_clk);
    req <= 24'h000022;
    n0 = ntk;
    wait_taken(n0);
    chk({16'h0, tvec}, 32'h000C);
    @(posedge sys_clk);
    req <= 24'h000002;
    n0 = ntk;
    repeat (20) @(posedge sys_clk);
    #1 chk({24'h0, ntk}, {24'h0, n0});
    @(posedge sys_clk);
    req <= '0;
  endtask
  task automatic sc_reloc();
    logic [7:0] n0;
    rd_reg(OFS_IRQ_STATUS);
    wr_reg(OFS_IRQ_MASK, 32'h7);
    wr_reg(OFS_CONTROL, 32'h1);
    wr_reg(OFS_CONTROL, 32'h2);
    #1 chk({31'h0, blocked}, 32'h1);
    repeat (6) @(posedge sys_clk);
    #1 chk({31'h0, blocked}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd_reg(OFS_CONTROL);
    chk(d & 32'h3, 32'h2);
    rd_reg(OFS_IRQ_STATUS);
    chk(d, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, irq}, 32'h0);
    rd_reg(OFS_VECTORS);
    chk(d, {BOOT, 16'h0000});
    // only the source enabled here may be fetched from the moved table
    wr_reg(OFS_SRC_ENABLE, 32'h00000001);
    n0 = ntk;
    dly <= 4'h0;
    req <= 24'h000001;
    wait_taken(n0);
    chk({16'h0, tvec}, {16'h0, BOOT} + 32'h2);
    @(posedge sys_clk);
    req <= '0;
  endtask
  // a select write after the window closes must not move the table back
  task automatic sc_late();
    wr_reg(OFS_CONTROL, 32'h1);
    repeat (6) @(posedge sys_clk);
    wr_reg(OFS_CONTROL, 32'h0);
    rd_reg(OFS_CONTROL);
    chk(d & 32'h3, 32'h2);
    rd_reg(OFS_IRQ_STATUS);
    chk(d, 32'h6);
    rd_reg(8'h40);
    chk(d, 32'h0);
    wr_reg(OFS_CONTROL, 32'h1);
    wr_reg(OFS_CONTROL, 32'h0);
    rd_reg(OFS_CONTROL);
    chk(d & 32'h3, 32'h0);
  endtask
  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    sc_vectors();
    sc_prio();
    sc_reloc();
    sc_late();
    wrap_up();
  end
endmodule
